// ==== dv/msa_host.sv ====
`timescale 1ns/1ns
`default_nettype none
module msa_host (
    // clock
    input  wire logic        aclk,
    // write channels
    output logic [7:0]       s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic [1:0]  s_axi_bresp,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // read channels
    output logic [7:0]       s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic [31:0] s_axi_rdata,
    input  wire logic [1:0]  s_axi_rresp,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    import msa_pkg::*;
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
        {s_axi_wvalid, s_axi_bready, s_axi_araddr} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // per-port counter: upper word first, reread until valid is set
    task automatic ctr_rd(input logic [9:0] off, output logic [31:0] v);
        logic [31:0] u;
        logic [31:0] l;
        logic [1:0]  r;
        axi_wr(OFF_CTRL, {16'h0000, 3'h0, 1'b1, TBL_STATS, off}, r);
        do axi_rd(OFF_DAT_UPR, u, r); while (!u[14]);
        axi_rd(OFF_DAT_LOW, l, r);
        v = {u[15:0], l[15:0]};
    endtask
    // drop counters carry no flags, so only the low word is fetched
    task automatic drop_rd(input logic [9:0] off, output logic [31:0] v);
        logic [1:0] r;
        axi_wr(OFF_CTRL, {16'h0000, 3'h0, 1'b1, TBL_STATS, off}, r);
        axi_rd(OFF_DAT_LOW, v, r);
    endtask
    task automatic st_wr(input logic [2:0] i, input logic [57:0] e);
        logic [1:0] r;
        axi_wr(OFF_DAT_TOP, 32'(e[57:48]), r);
        axi_wr(OFF_DAT_MID, 32'(e[47:32]), r);
        axi_wr(OFF_DAT_UPR, 32'(e[31:16]), r);
        axi_wr(OFF_DAT_LOW, 32'(e[15:0]), r);
        axi_wr(OFF_CTRL, {16'h0000, 4'h0, TBL_STATIC, 7'h00, i}, r);
    endtask
    task automatic st_rd(input logic [2:0] i, output logic [57:0] e);
        logic [31:0] t;
        logic [31:0] m;
        logic [31:0] u;
        logic [31:0] l;
        logic [1:0]  r;
        axi_wr(OFF_CTRL, {16'h0000, 3'h0, 1'b1, TBL_STATIC, 7'h00, i}, r);
        axi_rd(OFF_DAT_TOP, t, r);
        axi_rd(OFF_DAT_MID, m, r);
        axi_rd(OFF_DAT_UPR, u, r);
        axi_rd(OFF_DAT_LOW, l, r);
        e = {t[9:0], m[15:0], u[15:0], l[15:0]};
    endtask
endmodule
`default_nettype wire

// ==== dv/tb_mib_static_mac_indirect_access.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_mib_static_mac_indirect_access;
    import msa_pkg::*;
    localparam logic [47:0] MAC = 48'h1234_5678_9abc;
    logic          aclk, aresetn, s_axi_awvalid, s_axi_awready;
    logic          s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic          s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0]    s_axi_awaddr, s_axi_araddr;
    logic [31:0]   s_axi_wdata, s_axi_rdata;
    logic [3:0]    s_axi_wstrb, drop_inc;
    logic [1:0]    s_axi_bresp, s_axi_rresp;
    logic [63:0]   mib_inc;
    logic [2:0]    tx_disable, rx_disable;
    msa_lkp_req_t  lkp_req;
    msa_lkp_res_t  lkp_res;
    int            fails, comparisons;
    msa_top  uut (.*);
    msa_host host (.*);
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        if (fails == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // hold a set of increment lines for n cycles
    task automatic ev(input logic [67:0] m, input int n);
        {drop_inc, mib_inc} <= m;
        repeat (n) @(posedge aclk);
        {drop_inc, mib_inc} <= '0;
        @(posedge aclk);
    endtask
    task automatic lk(input logic da, input logic [3:0] f, input logic dh,
                      output msa_lkp_res_t q);
        lkp_req <= '{1'b1, da, MAC, f, 2'h0, dh, 3'h1};
        @(posedge aclk);
        lkp_req <= '0;
        #1 q = lkp_res;
        @(posedge aclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [31:0] v;
        logic [1:0]  r;
        host.axi_rd(OFF_CTRL, v, r);
        chk(v, 0);
        chk(r, RESP_OKAY);
        host.drop_rd(DROP_P2_RX, v);
        chk(v, 0);
        host.axi_rd(8'h14, v, r);
        chk(r, RESP_SLVERR);
        chk(v, 0);
        host.axi_wr(8'h22, 32'h0000_1c0e, r);
        chk(r, RESP_SLVERR);
        host.axi_wr(OFF_DAT_MID, 32'h0000_0000, r);
        chk(r, RESP_OKAY);
    endtask
    task automatic t_perport;
        logic [31:0] v;
        ev(68'(1) << 14, 3);
        ev(68'(1) << 46, 5);
        host.ctr_rd(10'h00e, v);
        chk(v, 32'h4000_0003);
        host.ctr_rd(10'h02e, v);
        chk(v, 32'h4000_0005);
        host.ctr_rd(10'h00e, v);
        chk(v, 32'h4000_0000);
    endtask
    task automatic t_drop;
        logic [9:0]  o [4] = '{DROP_P1_TX, DROP_P2_TX, DROP_P1_RX, DROP_P2_RX};
        logic [31:0] v;
        logic [1:0]  r;
        for (int i = 0; i < 4; i++) ev(68'(1) << (64 + i), i + 2);
        for (int i = 0; i < 4; i++) begin
            host.drop_rd(o[i], v);
            chk(v, i + 2);
            host.drop_rd(o[i], v);
            chk(v, i + 2);
            host.axi_rd(OFF_DAT_UPR, v, r);
            chk(v, 0);
        end
    endtask
    task automatic t_static;
        msa_st_entry_t e;
        msa_st_entry_t g;
        msa_lkp_res_t  q;
        e = '{4'h5, 1'b0, 1'b0, 1'b1, 3'h7, MAC};
        host.st_wr(3'h7, e);
        host.st_rd(3'h7, g);
        chk(g, e);
        host.st_rd(3'h6, g);
        chk(g, 0);
        lk(1'b1, 4'h9, 1'b0, q);
        chk({q.valid, q.override, q.static_hit, q.ports}, 6'h2e);
        lk(1'b1, 4'h9, 1'b1, q);
        chk({q.static_hit, q.dyn_used, q.ports}, 5'h16);
        lk(1'b0, 4'h5, 1'b1, q);
        chk(q.static_hit, 0);
        tx_disable <= 3'h2;
        lk(1'b1, 4'h5, 1'b0, q);
        chk(q.ports, 3'h4);
        rx_disable <= 3'h1;
        lk(1'b1, 4'h5, 1'b0, q);
        chk(q.ports, 3'h0);
        e.override = 1'b1;
        e.match_with_filter_id = 1'b1;
        host.st_wr(3'h7, e);
        lk(1'b1, 4'h5, 1'b0, q);
        chk({q.valid, q.override, q.static_hit, q.ports}, 6'h3e);
        lk(1'b1, 4'h9, 1'b0, q);
        chk(q.static_hit, 0);
        e.valid = 1'b0;
        host.st_wr(3'h7, e);
        lk(1'b1, 4'h5, 1'b0, q);
        chk(q.static_hit, 0);
        e.valid = 1'b1;
        e.fwd = 3'h0;
        host.st_wr(3'h7, e);
        lk(1'b1, 4'h5, 1'b0, q);
        chk({q.static_hit, q.ports}, 4'h8);
        tx_disable <= 3'h0;
        rx_disable <= 3'h0;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, mib_inc, drop_inc, tx_disable, rx_disable} = '0;
        lkp_req = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_perport();
        t_drop();
        t_static();
        test_done();
    end
    // the whole run needs well under two thousand cycles
    initial begin
        repeat (20000) @(posedge aclk);
        fails++;
        test_done();
    end
endmodule
`default_nettype wire

// ==== hdl/msa_top.sv ====
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module msa_top #(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned NPP    = 64,
    parameter int unsigned NST    = 8
) (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // axi4-lite slave
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // counter events from the switch core
    input  wire logic [NPP-1:0]         mib_inc,
    input  wire logic [3:0]             drop_inc,
    // forwarding lookup
    input  wire logic [2:0]             tx_disable,
    input  wire logic [2:0]             rx_disable,
    input  wire msa_pkg::msa_lkp_req_t  lkp_req,
    output msa_pkg::msa_lkp_res_t       lkp_res
);
    import msa_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // bus slave

    logic              aw_held_r;
    logic              w_held_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0]       wdata_r;
    logic [3:0]        wstrb_r;
    logic              bvalid_r;
    logic [1:0]        bresp_r;
    logic              rvalid_r;
    logic [31:0]       rdata_r;
    logic [1:0]        rresp_r;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  st);
        merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
    endfunction

    // returns a one-hot select for mapped, aligned offsets
    function automatic logic [4:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] o;
        o = 8'(a);
        reg_sel = '0;
        if (a[1:0] == 2'h0 && ADDR_W'(o) == a) begin
            reg_sel[0] = (o == OFF_CTRL);
            reg_sel[1] = (o == OFF_DAT_LOW);
            reg_sel[2] = (o == OFF_DAT_UPR);
            reg_sel[3] = (o == OFF_DAT_MID);
            reg_sel[4] = (o == OFF_DAT_TOP);
        end
    endfunction

    wire        aw_hs  = s_axi_awvalid && s_axi_awready;
    wire        w_hs   = s_axi_wvalid && s_axi_wready;
    wire        ar_hs  = s_axi_arvalid && s_axi_arready;
    wire        wr_go  = aw_held_r && w_held_r && !bvalid_r;
    wire [4:0]  wsel   = reg_sel(awaddr_r);
    wire [4:0]  rsel   = reg_sel(s_axi_araddr);

    assign s_axi_awready = !aw_held_r && !bvalid_r;
    assign s_axi_wready  = !w_held_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rdata   = rdata_r;
    assign s_axi_rresp   = rresp_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= '0;
            wdata_r   <= '0;
            wstrb_r   <= '0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
        end else begin
            if (aw_hs) begin
                aw_held_r <= 1'b1;
                awaddr_r  <= s_axi_awaddr;
            end
            if (w_hs) begin
                w_held_r <= 1'b1;
                wdata_r  <= s_axi_wdata;
                wstrb_r  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= (wsel == 5'h0) ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // indirect control and data words

    logic [15:0]      ctrl_r;
    logic [15:0]      dlow_r;
    logic [15:0]      dupr_r;
    logic [15:0]      dmid_r;
    logic [TOP_W-1:0] dtop_r;
    logic [15:0]      dlow_nxt;
    logic [15:0]      dupr_nxt;
    logic [15:0]      dmid_nxt;
    logic [TOP_W-1:0] dtop_nxt;
    logic [30:0]      pp_r [NPP];
    logic [15:0]      drop_r [4];
    msa_st_entry_t    st_mem_r [NST];

    wire [15:0] ctrl_nxt = merge16(ctrl_r, wdata_r, wstrb_r);
    wire        cmd_go   = wr_go && wsel[0];
    wire        cmd_rd   = ctrl_nxt[CMD_RD_BIT];
    wire [1:0]  cmd_tbl  = ctrl_nxt[TBL_MSB:TBL_LSB];
    wire [9:0]  cmd_addr = ctrl_nxt[IADDR_MSB:0];
    wire        is_pp    = (cmd_tbl == TBL_STATS) && (cmd_addr <= PP_LAST);
    wire [5:0]  pp_idx   = cmd_addr[5:0];
    wire        is_st    = (cmd_tbl == TBL_STATIC) && (cmd_addr < 10'(NST));
    wire [2:0]  st_idx   = cmd_addr[2:0];

    // drop counter slots 0..3 map onto the sparse 0x100 block
    logic       is_drop;
    logic [1:0] drop_idx;
    always_comb begin
        is_drop  = (cmd_tbl == TBL_STATS);
        drop_idx = 2'h0;
        unique case (cmd_addr)
            DROP_P1_TX: drop_idx = 2'h0;
            DROP_P2_TX: drop_idx = 2'h1;
            DROP_P1_RX: drop_idx = 2'h2;
            DROP_P2_RX: drop_idx = 2'h3;
            default:    is_drop  = 1'b0;
        endcase
    end

    wire pp_rd   = cmd_go && cmd_rd && is_pp;
    wire drop_rd = cmd_go && cmd_rd && is_drop;
    wire st_rd   = cmd_go && cmd_rd && is_st;
    wire st_wr   = cmd_go && !cmd_rd && is_st;
    wire [30:0] pp_sel = pp_r[pp_idx];
    msa_st_entry_t st_sel;
    assign st_sel = st_mem_r[st_idx];

    always_comb begin
        dlow_nxt = wsel[1] && wr_go ? merge16(dlow_r, wdata_r, wstrb_r) : dlow_r;
        dupr_nxt = wsel[2] && wr_go ? merge16(dupr_r, wdata_r, wstrb_r) : dupr_r;
        dmid_nxt = wsel[3] && wr_go ? merge16(dmid_r, wdata_r, wstrb_r) : dmid_r;
        dtop_nxt = dtop_r;
        if (wsel[4] && wr_go) begin
            dtop_nxt = TOP_W'(merge16(16'(dtop_r), wdata_r, wstrb_r));
        end
        if (cmd_go && cmd_rd) begin
            // a read of anything unmapped leaves zeros behind
            {dtop_nxt, dmid_nxt, dupr_nxt, dlow_nxt} = '0;
            if (pp_rd) begin
                // valid is always set: the value is latched in one cycle
                dlow_nxt = pp_sel[15:0];
                dupr_nxt = {pp_sel[30], 1'b1, pp_sel[29:16]};
            end else if (drop_rd) begin
                dlow_nxt = drop_r[drop_idx];
            end else if (st_rd) begin
                {dtop_nxt, dmid_nxt, dupr_nxt, dlow_nxt} = st_sel;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_r <= CTRL_RST;
            dlow_r <= DAT_RST;
            dupr_r <= DAT_RST;
            dmid_r <= DAT_RST;
            dtop_r <= TOP_W'(DAT_RST);
        end else begin
            if (cmd_go) begin
                ctrl_r <= ctrl_nxt;
            end
            dlow_r <= dlow_nxt;
            dupr_r <= dupr_nxt;
            dmid_r <= dmid_nxt;
            dtop_r <= dtop_nxt;
        end
    end

    // read data: data words are plain storage, reading has no side effect
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_r <= 1'b0;
            rdata_r  <= '0;
            rresp_r  <= RESP_OKAY;
        end else if (ar_hs) begin
            rvalid_r <= 1'b1;
            rresp_r  <= (rsel == 5'h0) ? RESP_SLVERR : RESP_OKAY;
            rdata_r  <= 32'(({16{rsel[0]}} & ctrl_r) | ({16{rsel[1]}} & dlow_r)
                      | ({16{rsel[2]}} & dupr_r) | ({16{rsel[3]}} & dmid_r)
                      | ({16{rsel[4]}} & 16'(dtop_r)));
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // counters

    genvar g;
    generate
        for (g = 0; g < NPP; g++) begin : g_pp
            wire hit_clr = pp_rd && (pp_idx == 6'(g));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    pp_r[g] <= PP_RST;
                end else if (hit_clr) begin
                    // an event in the clearing cycle survives as one count
                    pp_r[g] <= {1'b0, PP_CNT_W'(mib_inc[g])};
                end else if (mib_inc[g]) begin
                    if (&pp_r[g][29:0]) begin
                        pp_r[g] <= {1'b1, {PP_CNT_W{1'b0}}};
                    end else begin
                        pp_r[g] <= {pp_r[g][30], pp_r[g][29:0] + 30'h1};
                    end
                end
            end
        end
        for (g = 0; g < 4; g++) begin : g_drop
            // wraps silently; no clear on read
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    drop_r[g] <= DROP_RST;
                end else if (drop_inc[g]) begin
                    drop_r[g] <= drop_r[g] + 16'h0001;
                end
            end
        end
        // only a host write changes an entry, so nothing ages them out
        for (g = 0; g < NST; g++) begin : g_st
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    st_mem_r[g] <= ST_RST;
                end else if (st_wr && st_idx == 3'(g)) begin
                    st_mem_r[g] <= {dtop_r, dmid_r, dupr_r, dlow_r};
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // forwarding lookup

    function automatic logic entry_match(input msa_st_entry_t e,
                                         input msa_lkp_req_t  r);
        entry_match = e.valid && (e.mac == r.mac)
                      && (!e.match_with_filter_id || e.filter_identifier == r.filter_identifier);
    endfunction

    function automatic logic [2:0] gate_ports(input logic [2:0] p,
                                              input logic       ovr,
                                              input logic [1:0] ing);
        gate_ports = p;
        if (!ovr) begin
            gate_ports = rx_disable[ing] ? 3'h0 : (p & ~tx_disable);
        end
    endfunction

    logic          st_hit;
    msa_st_entry_t st_win;
    logic [2:0]    st_ports;
    msa_lkp_res_t  res_nxt;
    msa_lkp_res_t  res_r;

    // lowest index wins among several matching entries
    always_comb begin
        st_hit = 1'b0;
        st_win = ST_RST;
        for (int i = NST - 1; i >= 0; i--) begin
            if (lkp_req.is_da && entry_match(st_mem_r[i], lkp_req)) begin
                st_hit = 1'b1;
                st_win = st_mem_r[i];
            end
        end
    end

    wire [2:0] ing_mask = 3'h1 << lkp_req.ingress;
    assign st_ports = (st_win.fwd == FWD_BCAST) ? (FWD_BCAST & ~ing_mask)
                                                : st_win.fwd;

    always_comb begin
        res_nxt       = '0;
        res_nxt.valid = lkp_req.valid;
        if (st_hit) begin
            res_nxt.static_hit = 1'b1;
            res_nxt.override   = st_win.override;
            res_nxt.ports = gate_ports(st_ports, st_win.override,
                                       lkp_req.ingress);
        end else if (lkp_req.dyn_hit) begin
            res_nxt.dyn_used = 1'b1;
            res_nxt.ports = gate_ports(lkp_req.dyn_ports, 1'b0,
                                       lkp_req.ingress);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            res_r <= '0;
        end else begin
            res_r <= lkp_req.valid ? res_nxt : '0;
        end
    end
    assign lkp_res = res_r;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    logic [5:0] chk_pp_idx_r;
    logic [1:0] chk_dr_idx_r;
    always_ff @(posedge aclk) begin
        chk_pp_idx_r <= pp_idx;
        chk_dr_idx_r <= drop_idx;
    end

    sequence s_pp_cmd;
        pp_rd && !mib_inc[pp_idx];
    endsequence
    property p_pp_clear;
        s_pp_cmd |=> pp_r[chk_pp_idx_r] == PP_RST;
    endproperty
    a_pp_clear: assert property (p_pp_clear) else $error("counter not cleared");

    property p_pp_latch;
        pp_rd |=> dlow_r == $past(pp_sel[15:0]) && dupr_r[14] == 1'b1;
    endproperty
    a_pp_latch: assert property (p_pp_latch) else $error("bad counter latch");

    property p_drop_keep;
        drop_rd && !drop_inc[drop_idx] |=>
            drop_r[chk_dr_idx_r] == $past(drop_r[drop_idx]) && dupr_r == 16'h0000;
    endproperty
    a_drop_keep: assert property (p_drop_keep) else $error("drop counter disturbed");

    property p_ovf;
        !pp_rd && mib_inc[0] && (&pp_r[0][29:0]) |=> pp_r[0][30] && pp_r[0][29:0] == 30'h0;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not flagged");

    property p_st_write;
        st_wr |=> st_mem_r[$past(st_idx)] == $past({dtop_r, dmid_r, dupr_r, dlow_r});
    endproperty
    a_st_write: assert property (p_st_write) else $error("static write lost");

    property p_sa_only_dyn;
        lkp_req.valid && !lkp_req.is_da |=> !lkp_res.static_hit;
    endproperty
    a_sa_only_dyn: assert property (p_sa_only_dyn) else $error("static hit on source");

    property p_static_first;
        lkp_req.valid && st_hit && lkp_req.dyn_hit |=> lkp_res.static_hit && !lkp_res.dyn_used;
    endproperty
    a_static_first: assert property (p_static_first) else $error("dynamic beat static");

    sequence s_wr_both;
        aw_held_r && w_held_r && !bvalid_r;
    endsequence
    property p_bresp;
        s_wr_both |=> s_axi_bvalid ##0 (!aw_held_r && !w_held_r);
    endproperty
    a_bresp: assert property (p_bresp) else $error("write answer late");
endmodule
`default_nettype wire

// ==== include/msa_pkg.sv ====
`default_nettype none
package msa_pkg;
    // register byte offsets on the lite bus
    localparam logic [7:0] OFF_CTRL     = 8'h00;
    localparam logic [7:0] OFF_DAT_LOW  = 8'h04;
    localparam logic [7:0] OFF_DAT_UPR  = 8'h08;
    localparam logic [7:0] OFF_DAT_MID  = 8'h0c;
    localparam logic [7:0] OFF_DAT_TOP  = 8'h10;
    // control word layout
    localparam int unsigned CMD_RD_BIT  = 12;
    localparam int unsigned TBL_MSB     = 11;
    localparam int unsigned TBL_LSB     = 10;
    localparam int unsigned IADDR_MSB   = 9;
    localparam logic [1:0]  TBL_STATIC  = 2'h0;
    localparam logic [1:0]  TBL_STATS   = 2'h3;
    // counter address map
    localparam logic [9:0]  PP_LAST     = 10'h03f;
    localparam logic [9:0]  DROP_P1_TX  = 10'h100;
    localparam logic [9:0]  DROP_P2_TX  = 10'h101;
    localparam logic [9:0]  DROP_P1_RX  = 10'h103;
    localparam logic [9:0]  DROP_P2_RX  = 10'h104;
    localparam int unsigned PP_CNT_W    = 30;
    localparam int unsigned DROP_W      = 16;
    localparam int unsigned TOP_W       = 10;
    // reset values
    localparam logic [15:0] CTRL_RST    = 16'h0000;
    localparam logic [15:0] DAT_RST     = 16'h0000;
    localparam logic [30:0] PP_RST      = 31'h0000_0000;
    localparam logic [15:0] DROP_RST    = 16'h0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [2:0]  FWD_BCAST   = 3'h7;

    // static entry: fid 57-54, match_with_filter_id 53, override 52, valid 51,
    // forwarding ports 50-48, mac 47-0
    typedef struct packed {
        logic [3:0]  filter_identifier;
        logic        match_with_filter_id;
        logic        override;
        logic        valid;
        logic [2:0]  fwd;
        logic [47:0] mac;
    } msa_st_entry_t;
    localparam msa_st_entry_t ST_RST = '0;

    typedef struct packed {
        logic        valid;
        logic        is_da;
        logic [47:0] mac;
        logic [3:0]  filter_identifier;
        logic [1:0]  ingress;
        logic        dyn_hit;
        logic [2:0]  dyn_ports;
    } msa_lkp_req_t;

    typedef struct packed {
        logic        valid;
        logic        static_hit;
        logic        dyn_used;
        logic        override;
        logic [2:0]  ports;
    } msa_lkp_res_t;
endpackage
`default_nettype wire
